// ---- core/dip_pkg.sv ----
package dip_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int VOLT_W = 16;
  localparam int TIME_W = 16;
  localparam int EV_W   = 5;
  localparam int PROT_W = 6;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LEVELS   = 8'h04;
  localparam logic [7:0] ADDR_WINDOW   = 8'h08;
  localparam logic [7:0] ADDR_DURATION = 8'h0c;
  localparam logic [7:0] ADDR_DELAY    = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h20;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_RAPID   = 1;
  localparam int CTRL_RESTART = 2;
  localparam int CTRL_EXT_SRC = 3;
  localparam int CTRL_STARTER = 4;
  localparam logic [1:0] STARTER_DIRECT_ONLINE = 2'h0;
  localparam logic [1:0] STARTER_REVERSING     = 2'h1;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] LEVELS_RESET   = 32'h0000_0000;
  localparam logic [31:0] WINDOW_RESET   = 32'h0000_00c8;
  localparam logic [31:0] DURATION_RESET = 32'h0000_07d0;
  localparam logic [31:0] DELAY_RESET    = 32'h0000_01f4;
  // ----------------------------------------
  // event bits
  // ----------------------------------------
  localparam int EV_START   = 0;
  localparam int EV_END     = 1;
  localparam int EV_DROP    = 2;
  localparam int EV_ERROR   = 3;
  localparam int EV_RESTART = 4;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS     = 50;
  localparam int MS_NS      = 1000000;
  localparam int MS_CYCLES  = MS_NS / CLK_NS;
  localparam logic [15:0] DOUBLE_DIP_MS = 16'h03e8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {ST_IDLE, ST_RIDE, ST_SHED, ST_DELAY, ST_HOLD} state_type;
endpackage : dip_pkg

// ---- core/voltage_dip_load_shedding.sv ----
// Operation
// - error as soon as a dip lasts longer than the maximum duration
// - recovery inside the autorestart window keeps the relay energised
// - after a dip, restart only if enabled, after the restart delay
// - dip detection and reactions only while the dip function is enabled
// - start below the dip level, end above the restart level
// - dip past the window drops relay; restart or stay off after it
// - suppress undervoltage, power-factor and power alarms during a dip
// - with lockout, second dip within one second drops contactors at once
// - after lockout drop, restart after delay only if restart enabled
// - trigger from own measurement or from external low-voltage input
// - dip levels apply only with the internal measurement as source
// - function available only for direct-online or reversing starters
// - power-factor and power supervision off in test position and in dips
`timescale 1ns/1ps
`default_nettype none
module voltage_dip_load_shedding #(
  parameter int unsigned ms_cycles = dip_pkg::MS_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [dip_pkg::VOLT_W-1:0] voltage_value,
  input  wire logic                       ext_low_voltage,
  input  wire logic                       test_position,
  input  wire logic                       run_request,
  input  wire logic [dip_pkg::PROT_W-1:0] protect_in,
  output logic [dip_pkg::PROT_W-1:0]      protect_out,
  output logic                            relay_on,
  output logic                            dip_error,
  output logic                            dip_active,
  output logic                            irq
);
  import dip_pkg::*;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  wire  [1:0] pin_raw = {test_position, ext_low_voltage};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_reg[gi]    <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          // a change counts only once stages two and three agree
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate
  wire ext_low  = pin_reg[0];
  wire test_pos = pin_reg[1];
  // ----------------------------------------
  // registers and bus slave
  // ----------------------------------------
  logic [31:0] ctrl_reg, levels_reg, window_reg, duration_reg, delay_reg;
  logic [EV_W-1:0] irq_stat_reg, irq_en_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_full_reg, w_full_reg;
  logic [EV_W-1:0] ev;
  logic [31:0] status_word;
  wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire wr_ctrl  = do_write & (aw_addr_reg == ADDR_CTRL);
  wire wr_lvl   = do_write & (aw_addr_reg == ADDR_LEVELS);
  wire wr_win   = do_write & (aw_addr_reg == ADDR_WINDOW);
  wire wr_dur   = do_write & (aw_addr_reg == ADDR_DURATION);
  wire wr_dly   = do_write & (aw_addr_reg == ADDR_DELAY);
  wire wr_clr   = do_write & (aw_addr_reg == ADDR_IRQ_CLR);
  wire wr_en    = do_write & (aw_addr_reg == ADDR_IRQ_EN);
  wire wr_ro    = (aw_addr_reg == ADDR_STATUS) | (aw_addr_reg == ADDR_IRQ_STAT);
  wire wr_hit   = wr_ctrl | wr_lvl | wr_win | wr_dur | wr_dly | wr_clr | wr_en;
  wire [EV_W-1:0] clr_bits = wr_clr ? (w_data_reg[EV_W-1:0] & wmask[EV_W-1:0]) : '0;
  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (w_data_reg & wmask);
  endfunction : merge
  wire [31:0] en_merged = merge({27'h0, irq_en_reg});
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire rd_hit  = (s_axi_araddr <= ADDR_IRQ_EN) & (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_word =
    (s_axi_araddr == ADDR_CTRL)     ? ctrl_reg :
    (s_axi_araddr == ADDR_LEVELS)   ? levels_reg :
    (s_axi_araddr == ADDR_WINDOW)   ? window_reg :
    (s_axi_araddr == ADDR_DURATION) ? duration_reg :
    (s_axi_araddr == ADDR_DELAY)    ? delay_reg :
    (s_axi_araddr == ADDR_STATUS)   ? status_word :
    (s_axi_araddr == ADDR_IRQ_STAT) ? {27'h0, irq_stat_reg} :
    (s_axi_araddr == ADDR_IRQ_EN)   ? {27'h0, irq_en_reg} : 32'h0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit | wr_ro) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full_reg   <= 1'b0;
        w_full_reg    <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg     <= CTRL_RESET;
      levels_reg   <= LEVELS_RESET;
      window_reg   <= WINDOW_RESET;
      duration_reg <= DURATION_RESET;
      delay_reg    <= DELAY_RESET;
      irq_en_reg   <= '0;
      irq_stat_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= merge(ctrl_reg);
      if (wr_lvl)  levels_reg <= merge(levels_reg);
      if (wr_win)  window_reg <= merge(window_reg);
      if (wr_dur)  duration_reg <= merge(duration_reg);
      if (wr_dly)  delay_reg <= merge(delay_reg);
      if (wr_en)   irq_en_reg <= en_merged[EV_W-1:0];
      // a new event wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~clr_bits) | ev;
    end
  end
  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  wire [1:0] starter = ctrl_reg[CTRL_STARTER+:2];
  wire starter_ok = (starter == STARTER_DIRECT_ONLINE) | (starter == STARTER_REVERSING);
  wire fn_on      = ctrl_reg[CTRL_ENABLE] & starter_ok;
  wire rapid      = ctrl_reg[CTRL_RAPID];
  wire auto_rst   = ctrl_reg[CTRL_RESTART];
  wire ext_src    = ctrl_reg[CTRL_EXT_SRC];
  wire [TIME_W-1:0] win_ms = window_reg[TIME_W-1:0];
  wire [TIME_W-1:0] dur_ms = duration_reg[TIME_W-1:0];
  wire [TIME_W-1:0] dly_ms = delay_reg[TIME_W-1:0];
  wire [VOLT_W-1:0] start_lvl   = levels_reg[VOLT_W-1:0];
  wire [VOLT_W-1:0] restart_lvl = levels_reg[31:16];
  // ----------------------------------------
  // millisecond tick and timers
  // ----------------------------------------
  logic [15:0] div_reg;
  logic        tick_reg;
  wire div_wrap = (div_reg == 16'(ms_cycles - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg  <= 16'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_wrap ? 16'h0 : div_reg + 16'h1;
      tick_reg <= div_wrap;
    end
  end
  state_type state_reg, state_next;
  logic dip_reg, seen_reg;
  logic [TIME_W-1:0] dip_ms_reg, dly_cnt_reg, since_reg;
  // internal source uses levels, external source ignores them
  wire low_int   = voltage_value < start_lvl;
  wire high_int  = voltage_value > restart_lvl;
  wire dip_start = fn_on & ~dip_reg & (ext_src ? ext_low : low_int);
  wire dip_end   = fn_on & dip_reg & (ext_src ? ~ext_low : high_int);
  wire quick     = rapid & seen_reg & (since_reg < DOUBLE_DIP_MS);
  wire over_dur  = dip_ms_reg > dur_ms;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dip_reg     <= 1'b0;
      dip_ms_reg  <= '0;
      dly_cnt_reg <= '0;
      since_reg   <= '0;
      seen_reg    <= 1'b0;
    end else begin
      if (!fn_on) dip_reg <= 1'b0;
      else if (dip_start) dip_reg <= 1'b1;
      else if (dip_end) dip_reg <= 1'b0;
      // dip timer zeroes at each start and freezes once the dip ends; delay timer runs only in ST_DELAY
      if (dip_start) dip_ms_reg <= '0;
      else if (dip_reg & tick_reg & (dip_ms_reg != '1)) dip_ms_reg <= dip_ms_reg + 16'h1;
      if (state_reg != ST_DELAY) dly_cnt_reg <= '0;
      else if (tick_reg & (dly_cnt_reg != '1)) dly_cnt_reg <= dly_cnt_reg + 16'h1;
      // saturates at one second, enough to judge a double dip
      if (dip_start) since_reg <= '0;
      else if (tick_reg & (since_reg < DOUBLE_DIP_MS)) since_reg <= since_reg + 16'h1;
      if (!fn_on) seen_reg <= 1'b0;
      else if (dip_start) seen_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // reaction state machine
  // ----------------------------------------
  logic err_next;
  always_comb begin
    state_next = state_reg;
    err_next   = dip_error;
    ev         = '0;
    ev[EV_START] = dip_start;
    ev[EV_END]   = dip_end;
    case (state_reg)
      ST_IDLE, ST_DELAY: begin
        if (dip_start & quick) begin
          state_next  = ST_SHED;
          ev[EV_DROP] = run_request;
        end else if (dip_start) begin
          state_next = ST_RIDE;
        end else if ((state_reg == ST_DELAY) & (dly_cnt_reg >= dly_ms)) begin
          state_next     = ST_IDLE;
          ev[EV_RESTART] = 1'b1;
        end
      end
      ST_RIDE: begin
        if (over_dur) begin
          state_next   = ST_HOLD;
          err_next     = 1'b1;
          ev[EV_ERROR] = 1'b1;
        end else if (dip_end) begin
          state_next = ST_IDLE;
        end else if (dip_ms_reg >= win_ms) begin
          state_next  = ST_SHED;
          ev[EV_DROP] = run_request;
        end
      end
      ST_SHED: begin
        if (over_dur) begin
          state_next   = ST_HOLD;
          err_next     = 1'b1;
          ev[EV_ERROR] = 1'b1;
        end else if (dip_end) begin
          state_next = auto_rst ? ST_DELAY : ST_HOLD;
        end
      end
      ST_HOLD: begin
        // stays off until the run request is withdrawn and mains is back
        if (!run_request & !dip_reg) begin
          state_next = ST_IDLE;
          err_next   = 1'b0;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!fn_on) begin
      state_next = ST_IDLE;
      err_next   = 1'b0;
    end
  end
  wire relay_next = run_request & ((state_next == ST_IDLE) | (state_next == ST_RIDE));
  wire dip_now    = fn_on & (dip_start | (dip_reg & ~dip_end));
  wire [PROT_W-1:0] inhibit = {{4{dip_now | test_pos}}, {2{dip_now}}};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      relay_on    <= 1'b0;
      dip_error   <= 1'b0;
      dip_active  <= 1'b0;
      protect_out <= '0;
      irq         <= 1'b0;
    end else begin
      state_reg   <= state_next;
      relay_on    <= relay_next;
      dip_error   <= err_next;
      dip_active  <= dip_now;
      protect_out <= protect_in & ~inhibit;
      irq         <= |(((irq_stat_reg & ~clr_bits) | ev) & irq_en_reg);
    end
  end
  assign status_word = {26'h0, (state_reg == ST_DELAY), (state_reg == ST_SHED),
                        dip_error, relay_on, dip_reg, fn_on};
endmodule : voltage_dip_load_shedding
`default_nettype wire

// ---- testbench/dip_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module dip_assertions #(
  parameter int unsigned ms_cycles = 20
) (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       run_request,
  input wire logic [dip_pkg::PROT_W-1:0] protect_in,
  input wire logic [dip_pkg::PROT_W-1:0] protect_out,
  input wire logic                       relay_on,
  input wire logic                       dip_error,
  input wire logic                       dip_active
);
  import dip_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not on time");
  // ----------------------------------------
  // dip reactions
  // ----------------------------------------
  a_relay_needs_run: assert property (relay_on |-> $past(run_request))
    else $error("relay on without run request");
  a_error_relay_off: assert property (dip_error |-> !relay_on)
    else $error("relay on while duration error");
  a_error_in_dip: assert property ($rose(dip_error) |-> dip_active && !relay_on)
    else $error("duration error outside a dip");
  // mask checks also require the dip in the cycle before, though both outputs are registered from dip_now at the same edge
  a_uv_masked: assert property (dip_active && $past(dip_active) |-> protect_out[1:0] == 2'h0)
    else $error("undervoltage alarm passed during dip");
  a_uv_passed: assert property (!dip_active && !$past(dip_active) && $past(rstn)
                                |-> protect_out[1:0] == $past(protect_in[1:0]))
    else $error("undervoltage alarm lost outside dip");
  a_load_masked: assert property (dip_active && $past(dip_active) |-> protect_out[5:2] == 4'h0)
    else $error("load alarm passed during dip");
endmodule : dip_assertions
`default_nettype wire

// ---- testbench/mains_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mains_model (
  input  wire logic        clk,
  input  wire logic        relay_on,
  input  wire logic [15:0] volt_set,
  input  wire logic        low_set,
  output logic [15:0]      voltage_value,
  output logic             ext_low_voltage,
  output int               drops
);
  logic relay_prev;
  // one process owns every output
  // the contactor counts every opening, so a ride-through that blips the coil is caught
  initial begin
    voltage_value = 16'hc8;
    ext_low_voltage = 1'h0;
    drops = 0;
    relay_prev = 1'h0;
    forever begin
      @(posedge clk);
      voltage_value <= volt_set;
      ext_low_voltage <= low_set;
      relay_prev <= relay_on;
      if (relay_prev && !relay_on) drops <= drops + 1;
    end
  end
endmodule : mains_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dip_pkg::*;
  logic        clk, rstn, run_request, test_position, ext_low_voltage, low_set;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, relay_on, dip_error, dip_active, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] voltage_value, volt_set;
  logic [5:0]  protect_in, protect_out;
  int          mismatches, checked, drops;
  logic [33:0] exp_q[$];
  logic [31:0] cv[4] = '{32'h4, 32'h25, 32'h35, 32'h15};
  voltage_dip_load_shedding #(.ms_cycles(20)) i_voltage_dip_load_shedding (.*);
  mains_model i_mains_model (.clk(clk), .relay_on(relay_on), .volt_set(volt_set), .low_set(low_set),
    .voltage_value(voltage_value), .ext_low_voltage(ext_low_voltage), .drops(drops));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  always @(posedge clk) protect_in <= 6'($urandom);
  initial begin
    #(60000 * 50);
    mismatches++;
    tally_and_finish();
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    exp_q.push_back(34'(er));
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    exp_q.push_back({er, d});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic dip(input logic [15:0] v, input int n);
    @(posedge clk);
    volt_set <= v;
    wt(n);
  endtask : dip
  task automatic cycle_run();
    run_request <= 1'h0;
    wt(5);
    run_request <= 1'h1;
    wt(5);
  endtask : cycle_run
  initial begin
    void'($urandom(22));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rstn} = '0;
    {run_request, test_position, low_set} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    volt_set = 16'hc8;
    wt(8);
    rstn <= 1'h1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_WINDOW, WINDOW_RESET);
    rd(ADDR_DURATION, DURATION_RESET);
    rd(ADDR_DELAY, DELAY_RESET);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h42, 32'h1, RESP_SLVERR);
    wr(ADDR_LEVELS, 32'h0078_0064);
    wr(ADDR_WINDOW, 32'h3);
    wr(ADDR_DURATION, 32'ha);
    wr(ADDR_DELAY, 32'h2);
    wr(ADDR_IRQ_EN, 32'h1f);
    wr(ADDR_CTRL, 32'h5);
    run_request <= 1'h1;
    wt(5);
    rd(ADDR_STATUS, 32'h5);
    // short dip rides through
    dip(16'h5a, 30);
    chk(dip_active, 1'h1);
    chk(relay_on, 1'h1);
    dip(16'hc8, 10);
    chk(dip_active, 1'h0);
    chk(34'(drops), 34'h0);
    chk(irq, 1'h1);
    rd(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_EN, 32'h0);
    wt(3);
    chk(irq, 1'h0);
    wr(ADDR_IRQ_CLR, 32'h1f);
    wr(ADDR_IRQ_EN, 32'h1f);
    rd(ADDR_IRQ_STAT, 32'h0);
    // long dip drops, hysteresis band holds the dip, then delayed restart
    dip(16'h5a, 100);
    chk(relay_on, 1'h0);
    dip(16'h6e, 20);
    chk(dip_active, 1'h1);
    dip(16'hc8, 10);
    chk(relay_on, 1'h0);
    wt(60);
    chk(relay_on, 1'h1);
    chk(34'(drops), 34'h1);
    rd(ADDR_IRQ_STAT, 32'h17);
    wr(ADDR_CTRL, 32'h1);
    dip(16'h5a, 100);
    dip(16'hc8, 100);
    chk(relay_on, 1'h0);
    cycle_run();
    chk(relay_on, 1'h1);
    wr(ADDR_CTRL, 32'h5);
    dip(16'h5a, 180);
    chk(dip_error, 1'h0);
    wt(70);
    chk(dip_error, 1'h1);
    dip(16'hc8, 10);
    cycle_run();
    chk(dip_error, 1'h0);
    // external monitor: levels are ignored
    wr(ADDR_CTRL, 32'hd);
    dip(16'h0, 40);
    chk(dip_active, 1'h0);
    low_set <= 1'h1;
    wt(30);
    chk(dip_active, 1'h1);
    low_set <= 1'h0;
    wt(20);
    chk(dip_active, 1'h0);
    chk(relay_on, 1'h1);
    dip(16'hc8, 5);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, cv[i]);
      dip(16'h5a, 40);
      chk(dip_active, i == 3);
      dip(16'hc8, 80);
    end
    test_position <= 1'h1;
    wt(10);
    chk(protect_out[5:2], 4'h0);
    test_position <= 1'h0;
    // double dip with lockout
    // switching off forgets the earlier dip, so the first one here is not a double
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h7);
    dip(16'h5a, 20);
    chk(relay_on, 1'h1);
    dip(16'hc8, 100);
    chk(relay_on, 1'h1);
    dip(16'h5a, 10);
    chk(relay_on, 1'h0);
    dip(16'hc8, 20);
    chk(relay_on, 1'h0);
    wt(60);
    chk(relay_on, 1'h1);
    wt(20000);
    dip(16'h5a, 10);
    chk(relay_on, 1'h1);
    dip(16'hc8, 40);
    tally_and_finish();
  end
endmodule : testbench
bind voltage_dip_load_shedding dip_assertions #(.ms_cycles(ms_cycles)) i_dip_assertions (.*);
`default_nettype wire
